// >>> verilog/csc_irq_defs.vh
// constants for the card status-change interrupt routing block
`ifndef CSC_IRQ_DEFS_VH
`define CSC_IRQ_DEFS_VH
`define CFG_OFFSET 12'h805
`define CFG_INDEX 8'h05
`define FLAG_OFFSET 12'h804
`define FLAG_INDEX 8'h04
`define CFG_RESET 8'h00
`define SEL_HI 7
`define SEL_LO 4
`define BIT_DETECT 3
`define BIT_READY 2
`define BIT_WARN 1
`define BIT_DEAD 0
`define SEL_NONE 4'h0
`define SEL_IRQ1 4'h1
`define SEL_SMI 4'h2
`define DIAG_PCI_BIT 5
`define GCTL_CLEAR_MODE_BIT 2
`define PIN_IDLE 5'h18
`endif

// >>> verilog/csc_route_decode.v
// decoder from route-select code to interrupt line outputs
`timescale 1ns/10ps
`default_nettype none
`include "csc_irq_defs.vh"
module csc_route_decode (
    input wire [3:0] sel_in,       // route-select code
    input wire req_in,             // combined pending request
    input wire diag_pci_in,        // diagnostic pci route default
    input wire pci_route_in,       // pci routing bit
    output reg [15:0] isa_irq_out, // one bit per isa line
    output reg smi_out,            // system management interrupt
    output reg pci_irq_out         // pci interrupt
);
    always @* begin
        isa_irq_out = 16'h0000;
        smi_out = 1'b0;
        pci_irq_out = 1'b0;
        if (sel_in == `SEL_NONE) begin
            // diag bit set makes the pci routing bit a don't care
            pci_irq_out = req_in & (diag_pci_in | pci_route_in); // R2 R3
        end else if (sel_in == `SEL_SMI) begin
            smi_out = req_in; // R1
        end else begin
            isa_irq_out[sel_in] = req_in; // R1
        end
    end
endmodule
`default_nettype wire

// >>> verilog/card_status_irq_routing.v
// card status-change flags, source masks and interrupt routing
`timescale 1ns/10ps
`default_nettype none
`include "csc_irq_defs.vh"
// Function
// R1: route-select bits 7..4 pick IRQ1, SYSTEM_MANAGEMENT_IRQ, or IRQ3..IRQ15 by code.
// R2: select zero with the diagnostic bit set routes to pci regardless.
// R3: select zero and diagnostic bit clear: no isa line, pci if routing bit.
// R4: bit 3 lets a change on either card-detect input raise an interrupt.
// R5: bit 2 lets a rising READY edge raise an interrupt.
// R6: bit 1 lets a battery warning raise an interrupt.
// R7: bit 0 lets battery dead or the status-change pin raise an interrupt.
// R8: a clear enable suppresses its source; all config bits reset to zero.
// R9: config register sits at offset 805h and index 05h, all bits read/write.
// R10: a disabled source's flag reads zero; an enabled active source sets it.
// R11: flags clear on read or by writing one, chosen by global control bit 2.
// R12: the selected output is asserted while any enabled flag is pending.
module card_status_irq_routing (
    input wire clk_in,               // 100 MHz host clock
    input wire rst_in,               // async reset, active high
    input wire [11:0] addr_in,       // socket register byte offset
    input wire [7:0] index_in,       // compatibility set index
    input wire index_sel_in,         // access uses index_in, not addr_in
    input wire wr_in,                // write strobe, one cycle
    input wire rd_in,                // read strobe, one cycle
    input wire [7:0] wdata_in,       // write data
    output reg [7:0] rdata_out,      // read data, valid cycle after rd_in
    input wire diag_pci_route_default_in, // diagnostic pci route bit
    input wire pci_route_select_bit_in,   // pci routing bit
    input wire [7:0] global_ctrl_in, // global control register value
    input wire card_detect_one_n_in,  // card detect 1 pin, active low
    input wire card_detect_two_n_in,  // card detect 2 pin, active low
    input wire card_ready_in,         // card READY pin
    input wire battery_warn_in,       // battery warning condition
    input wire card_status_change_pin_n_in, // dead/status-change, low
    input wire io_card_in,            // an I/O card is installed
    output wire [15:0] isa_irq_out,  // isa interrupt lines
    output wire system_management_irq_out, // SYSTEM_MANAGEMENT_IRQ request
    output wire pci_irq_out          // pci interrupt request
);
    reg [7:0] cfg_r;
    reg [7:0] cfg_nxt;
    reg [3:0] flag_r;
    reg [3:0] flag_nxt;
    reg [7:0] rdata_nxt;
    reg [4:0] pin_s1_r;
    reg [4:0] pin_s2_r;
    reg [4:0] pin_d_r;
    wire [3:0] en;
    wire [3:0] evt;
    wire [3:0] clr;
    wire hit_cfg;
    wire hit_flag;
    wire cfg_wr;
    wire cfg_rd;
    wire flag_wr;
    wire flag_rd;
    wire clear_mode;
    wire rd_clear;
    wire wr_clear;
    wire req;
    wire cd1_now;
    wire cd2_now;
    wire ready_now;
    wire warn_now;
    wire dead_now;
    wire cd1_last;
    wire cd2_last;
    wire ready_last;

    // one decode serves both registers, in either address space
    function hit;
        input sel;
        input [11:0] a;
        input [7:0] i;
        input [11:0] off;
        input [7:0] idx;
        begin
            hit = sel ? (i == idx) : (a == off);
        end
    endfunction

    // a synchronised level that differs from its previous sample
    function changed;
        input now;
        input last;
        begin
            changed = now ^ last;
        end
    endfunction

    // low-to-high step between two synchronised samples
    function rose;
        input now;
        input last;
        begin
            rose = now & ~last;
        end
    endfunction

    // flag bits dropped by this access; a clearing read drops them all
    function [3:0] clear_mask;
        input rd_clr;
        input wr_clr;
        input [3:0] wdata;
        begin
            clear_mask = 4'h0;
            if (rd_clr)
                clear_mask = 4'hF;
            if (wr_clr)
                clear_mask = clear_mask | wdata;
        end
    endfunction

    assign hit_cfg = hit(index_sel_in, addr_in, index_in,
                         `CFG_OFFSET, `CFG_INDEX); // R9
    assign hit_flag = hit(index_sel_in, addr_in, index_in,
                          `FLAG_OFFSET, `FLAG_INDEX);
    assign en = cfg_r[3:0];

    // pins are asynchronous to the host clock; two stages before use.
    // reset loads the idle pin levels so that release shows no edge
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_r <= `PIN_IDLE;
            pin_s2_r <= `PIN_IDLE;
            pin_d_r <= `PIN_IDLE;
        end else begin
            pin_s1_r <= {card_detect_one_n_in, card_detect_two_n_in,
                         card_ready_in, battery_warn_in,
                         ~card_status_change_pin_n_in};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    assign cd1_now = pin_s2_r[4];
    assign cd2_now = pin_s2_r[3];
    assign ready_now = pin_s2_r[2];
    assign warn_now = pin_s2_r[1];
    assign dead_now = pin_s2_r[0];
    assign cd1_last = pin_d_r[4];
    assign cd2_last = pin_d_r[3];
    assign ready_last = pin_d_r[2];

    assign evt[`BIT_DETECT] = en[`BIT_DETECT] &
        (changed(cd1_now, cd1_last) | changed(cd2_now, cd2_last)); // R4
    // ready and warning carry no meaning with an I/O card installed
    assign evt[`BIT_READY] = en[`BIT_READY] & ~io_card_in &
        rose(ready_now, ready_last); // R5
    assign evt[`BIT_WARN] = en[`BIT_WARN] & ~io_card_in & warn_now; // R6
    assign evt[`BIT_DEAD] = en[`BIT_DEAD] & dead_now; // R7

    assign cfg_wr = wr_in & hit_cfg; // R9
    assign cfg_rd = rd_in & hit_cfg;
    assign flag_wr = wr_in & hit_flag;
    assign flag_rd = rd_in & hit_flag;
    assign clear_mode = global_ctrl_in[`GCTL_CLEAR_MODE_BIT];
    assign rd_clear = flag_rd & ~clear_mode; // R11
    assign wr_clear = flag_wr & clear_mode; // R11
    assign clr = clear_mask(rd_clear, wr_clear, wdata_in[3:0]);

    always @* begin
        // a new event wins over a clear in the same cycle, and a
        // disabled source loses its flag at once
        flag_nxt = ((flag_r & ~clr) | evt) & en; // R10 R8
    end

    always @* begin
        cfg_nxt = cfg_r;
        if (cfg_wr)
            cfg_nxt = wdata_in; // R9
    end

    // read data is taken on the strobe and held until the next read
    always @* begin
        rdata_nxt = rdata_out;
        if (cfg_rd)
            rdata_nxt = cfg_r; // R9
        else if (flag_rd)
            rdata_nxt = {4'h0, flag_r & en}; // R10
        else if (rd_in)
            rdata_nxt = 8'h00;
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r <= `CFG_RESET; // R8
        end else begin
            cfg_r <= cfg_nxt;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_r <= 4'h0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rdata_nxt;
        end
    end

    assign req = |(flag_r & en); // R12 R8

    csc_route_decode u_decode (
        .sel_in(cfg_r[`SEL_HI:`SEL_LO]),
        .req_in(req),
        .diag_pci_in(diag_pci_route_default_in),
        .pci_route_in(pci_route_select_bit_in),
        .isa_irq_out(isa_irq_out),
        .smi_out(system_management_irq_out),
        .pci_irq_out(pci_irq_out)
    );
endmodule
`default_nettype wire

// >>> bench/irq_route_monitor.sv
// assertion checker for status-change interrupt routing
`timescale 1ns/10ps
`default_nettype none
`include "csc_irq_defs.vh"
module irq_route_monitor (
    input wire logic clk_in, rst_in, index_sel_in, wr_in, rd_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] index_in, wdata_in, rdata_out,
    input wire logic diag_pci_route_default_in, pci_route_select_bit_in,
    input wire logic [15:0] isa_irq_out,
    input wire logic system_management_irq_out, pci_irq_out
);
    logic [7:0] cfg_r;
    wire logic hit = index_sel_in ? index_in == `CFG_INDEX
        : addr_in == `CFG_OFFSET;
    wire logic [3:0] sel = cfg_r[7:4];
    wire logic system_management_irq = system_management_irq_out;
    wire logic any = |isa_irq_out;
    wire logic rt = diag_pci_route_default_in | pci_route_select_bit_in;
    // shadow copy of the config byte, rebuilt from bus writes
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in) cfg_r <= `CFG_RESET;
        else if (wr_in && hit) cfg_r <= wdata_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_unused_lines: assert property (!isa_irq_out[0] && !isa_irq_out[2])
        else $error("isa 0 or 2 raised");
    a_single_line: assert property ($onehot0({isa_irq_out, system_management_irq}))
        else $error("several lines raised");
    a_isa_by_sel: assert property (any |-> isa_irq_out[sel])
        else $error("wrong isa line");
    a_smi_by_sel: assert property (system_management_irq |-> sel == `SEL_SMI)
        else $error("smi without its code");
    a_zero_quiet: assert property (sel == `SEL_NONE |-> !any && !system_management_irq)
        else $error("isa driven at code 0");
    a_pci_gate: assert property (
        pci_irq_out |-> sel == `SEL_NONE && rt)
        else $error("pci raised wrongly");
    a_cfg_read: assert property (
        $past(rd_in && hit) |-> rdata_out == $past(cfg_r))
        else $error("config readback");
    a_masked_quiet: assert property (cfg_r[3:0] == 4'h0
        && $past(cfg_r[3:0]) == 4'h0 |-> !any && !system_management_irq && !pci_irq_out)
        else $error("masked source raised");
endmodule
bind card_status_irq_routing irq_route_monitor mon (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .index_sel_in(index_sel_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .addr_in(addr_in),
    .index_in(index_in),
    .wdata_in(wdata_in),
    .rdata_out(rdata_out),
    .diag_pci_route_default_in(diag_pci_route_default_in),
    .pci_route_select_bit_in(pci_route_select_bit_in),
    .isa_irq_out(isa_irq_out),
    .system_management_irq_out(system_management_irq_out),
    .pci_irq_out(pci_irq_out)
);
`default_nettype wire

// >>> bench/host_irq_model.sv
// host interrupt controller model: reports the single raised line
`timescale 1ns/10ps
`default_nettype none
module host_irq_model (
    input wire logic [15:0] isa_irq_in, // isa request lines
    input wire logic smi_in, // system management request
    input wire logic pci_irq_in, // pci request
    output logic [4:0] host_line_out // IRQn, 10h smi, 11h pci, 1Fh many
);
    wire logic [17:0] req = {pci_irq_in, smi_in, isa_irq_in};
    always_comb begin
        host_line_out = 5'h00;
        for (int n = 0; n < 18; n++)
            if (req[n])
                host_line_out = host_line_out == 5'h00 ? 5'(n) : 5'h1F;
    end
endmodule
`default_nettype wire

// >>> bench/card_status_irq_routing_tb.sv
// self-checking bench for status-change interrupt routing
`timescale 1ns/10ps
`default_nettype none
`include "csc_irq_defs.vh"
module card_status_irq_routing_tb;
    logic clk_in = 0, rst_in = 1, index_sel_in = 0, wr_in = 0, rd_in = 0;
    logic [11:0] addr_in = 0;
    logic [7:0] index_in = 0, wdata_in = 0, global_ctrl_in = 0;
    logic diag_pci_route_default_in = 0, pci_route_select_bit_in = 0;
    logic card_detect_one_n_in = 1, card_detect_two_n_in = 1;
    logic card_ready_in = 0, battery_warn_in = 0, io_card_in = 0;
    logic card_status_change_pin_n_in = 1;
    wire logic [7:0] rdata_out;
    wire logic [15:0] isa_irq_out;
    wire logic system_management_irq_out, pci_irq_out;
    wire logic [4:0] host_line;
    int error_cnt = 0, total_checks = 0;
    always #5 clk_in = ~clk_in;
    card_status_irq_routing uut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .index_in(index_in),
        .index_sel_in(index_sel_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .wdata_in(wdata_in),
        .rdata_out(rdata_out),
        .diag_pci_route_default_in(diag_pci_route_default_in),
        .pci_route_select_bit_in(pci_route_select_bit_in),
        .global_ctrl_in(global_ctrl_in),
        .card_detect_one_n_in(card_detect_one_n_in),
        .card_detect_two_n_in(card_detect_two_n_in),
        .card_ready_in(card_ready_in),
        .battery_warn_in(battery_warn_in),
        .card_status_change_pin_n_in(card_status_change_pin_n_in),
        .io_card_in(io_card_in),
        .isa_irq_out(isa_irq_out),
        .system_management_irq_out(system_management_irq_out),
        .pci_irq_out(pci_irq_out)
    );
    host_irq_model host (
        .isa_irq_in(isa_irq_out),
        .smi_in(system_management_irq_out),
        .pci_irq_in(pci_irq_out),
        .host_line_out(host_line)
    );
    task automatic chk(input string n, input logic [7:0] e, s);
        total_checks++;
        if (e !== s) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk_in);
        #1 {addr_in, wdata_in, wr_in, rd_in} = {a, d, w, !w};
        @(posedge clk_in);
        #1 {wr_in, rd_in} = 2'h0;
    endtask
    function automatic logic [4:0] route(input logic [3:0] s, input logic r);
        route = s == `SEL_SMI ? 5'h10 :
            s != `SEL_NONE ? {1'b0, s} : {r, 4'h1} & {5{r}};
    endfunction
    task automatic pins(input int b, input logic v);
        case (b)
            4: card_detect_two_n_in = !v;
            3: card_detect_one_n_in = !v;
            2: card_ready_in = v;
            1: battery_warn_in = v;
            default: card_status_change_pin_n_in = !v;
        endcase
        repeat (6) @(posedge clk_in);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        int b;
        logic [3:0] s, en;
        logic [7:0] want;
        void'($urandom(32'hD927DC6E));
        repeat (10) @(posedge clk_in);
        #1 rst_in = 0;
        acc(0, `CFG_OFFSET, 0);
        chk("cfg reset", `CFG_RESET, rdata_out);
        acc(0, 12'h8FF, 0);
        chk("unmapped", 8'h00, rdata_out);
        for (int i = 0; i < 20; i++) begin
            s = i < 16 ? 4'(i) : `SEL_NONE;
            b = $urandom % 4;
            en = 4'($urandom);
            if (i[0] || i < 4) en[b] = 1;
            {diag_pci_route_default_in, pci_route_select_bit_in} =
                i > 15 ? 2'(i) : 2'($urandom);
            acc(1, `CFG_OFFSET, {s, en});
            {index_sel_in, index_in} = {1'b1, `CFG_INDEX};
            acc(0, 0, 0);
            index_sel_in = 0;
            chk("cfg readback", {s, en}, rdata_out);
            pins(b, 1);
            want = 8'(route(s, diag_pci_route_default_in |
                pci_route_select_bit_in));
            if (!en[b])
                want = 8'h00;
            chk("routed line", want, host_line);
            pins(b, 0);
            acc(0, `FLAG_OFFSET, 0);
            chk("flag", en[b] ? 8'(1 << b) : 8'h00, rdata_out);
            acc(0, 12'h8FF, 0);
            chk("released", 8'h00, host_line);
            $display("test %0d done", i);
        end
        // corners: second detect pin, both clear modes, I/O card masking
        acc(1, `CFG_OFFSET, 8'h3F);
        pins(4, 1);
        chk("detect two", 8'h03, host_line);
        acc(1, `FLAG_OFFSET, 8'h0F);
        chk("write ignored", 8'h03, host_line);
        pins(4, 0);
        global_ctrl_in = 8'h04;
        {index_sel_in, index_in} = {1'b1, `FLAG_INDEX};
        acc(0, 0, 0);
        chk("flag by index", 8'h08, rdata_out);
        chk("read kept", 8'h03, host_line);
        acc(1, 0, 8'h08);
        chk("write cleared", 8'h00, host_line);
        index_sel_in = 0;
        io_card_in = 1;
        pins(2, 1);
        pins(1, 1);
        chk("io masked", 8'h00, host_line);
        acc(0, `FLAG_OFFSET, 0);
        chk("io flags", 8'h00, rdata_out);
        pins(2, 0);
        pins(1, 0);
        io_card_in = 0;
        $display("corner tests done");
        results();
    end
    initial begin
        #100000;
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
